// *** hdl/cgif_top.sv ***
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
// Functional notes
// [R1] Wake flag sets when the module leaves sleep, otherwise stays clear.
// [R2] Receive overflow sets the lost flag on the mailbox's selected line.
// [R3] Lost flag clears only when software clears that mailbox's pending bit.
// [R4] Bus-off flag sets on entering bus-off, stays clear while bus-on.
// [R5] Error-passive flag sets on entering error-passive state.
// [R6] Warning flag sets when either error counter reaches the warning level.
// [R7] Writes to flag bits seven to five are ignored.
// [R8] A five-bit vector shows the mailbox that set the mailbox flag.
// [R9] Vector holds until cleared or outranked, then shows highest pending.
// [R10] Normal mode: mailbox 31 ranks highest, lower numbers lower.
// [R11] Compat mode: four vector bits, mailbox 15 highest, 16 to 31 ignored.
// [R12] Vector value is meaningless when no mailbox flag is pending.
// [R13] Mailbox flag sets only for mailboxes whose mask bit is set.
// [R14] Global interrupts go to line one when level bit set, else zero.
// [R15] Each mailbox interrupts on line zero or one by its level bit.
module cgif_top
  import cgif_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic wake_event_i,
  input wire logic [31:0] rx_overflow_i,
  input wire logic [31:0] receive_pending_i,
  input wire logic [31:0] transmit_ack_i,
  input wire logic bus_off_i,
  input wire logic error_passive_i,
  input wire logic [7:0] tx_err_cnt_i,
  input wire logic [7:0] rx_err_cnt_i,
  output logic irq_line_zero_o,
  output logic irq_line_one_o,
  output logic irq_o
);

  // Sticky global flags of one line
  typedef struct packed {
    logic wake;
    logic bo;
    logic ep;
    logic wl;
  } cgif_gflag_t;

  typedef struct packed {
    cgif_gflag_t [1:0] gflag;
    logic [31:0] lost;
    logic [31:0] rmp_q;
    logic bo_q;
    logic ep_q;
    logic wl_q;
    logic [4:0] gmask;
    logic global_line_select;
    logic i1en;
    logic i0en;
    logic [31:0] mim;
    logic [31:0] mil;
    logic compat;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } cgif_state_t;

  cgif_state_t st_r;
  cgif_state_t st_nxt;

  cgif_vec_if vif0 ();
  cgif_vec_if vif1 ();

  logic [31:0] mbx_flag;
  logic [31:0] mbx_pend0;
  logic [31:0] mbx_pend1;
  logic [31:0] mbx_vis;
  logic gmif0;
  logic gmif1;
  logic rml0;
  logic rml1;
  logic warn_now;
  logic wr_go;
  logic rd_go;
  logic [31:0] gif0_word;
  logic [31:0] gif1_word;

  // Per-mailbox flag: acknowledged transmit or pending receive
  assign mbx_flag = transmit_ack_i | receive_pending_i;
  assign mbx_vis = st_r.compat ? COMPAT_MBX_MASK : ~RST_WORD; // [R11]
  assign mbx_pend0 = mbx_flag & st_r.mim & ~st_r.mil & mbx_vis; // [R13] [R15]
  assign mbx_pend1 = mbx_flag & st_r.mim & st_r.mil & mbx_vis; // [R13] [R15]
  assign gmif0 = |mbx_pend0;
  assign gmif1 = |mbx_pend1;
  assign rml0 = |(st_r.lost & ~st_r.mil); // [R2]
  assign rml1 = |(st_r.lost & st_r.mil); // [R2]
  assign warn_now = (tx_err_cnt_i >= WARN_LEVEL) || (rx_err_cnt_i >= WARN_LEVEL); // [R6]

  // One vector selector per line
  assign vif0.pend = mbx_pend0;
  assign vif0.compat = st_r.compat;
  assign vif1.pend = mbx_pend1;
  assign vif1.compat = st_r.compat;

  cgif_vec u_vec0 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .vif(vif0.sel)
  );

  cgif_vec u_vec1 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .vif(vif1.sel)
  );

  // Flag word images; bits 7 to 5 read as zero  [R7]
  always_comb begin
    gif0_word = RST_WORD;
    gif0_word[GIF_GMIF_BIT] = gmif0;
    gif0_word[GIF_WAKE_BIT] = st_r.gflag[0].wake;
    gif0_word[GIF_RML_BIT] = rml0;
    gif0_word[GIF_BO_BIT] = st_r.gflag[0].bo;
    gif0_word[GIF_EP_BIT] = st_r.gflag[0].ep;
    gif0_word[GIF_WL_BIT] = st_r.gflag[0].wl;
    gif0_word[GIF_VEC_LSB +: VEC_W] = vif0.vec; // [R8]
    gif1_word = RST_WORD;
    gif1_word[GIF_GMIF_BIT] = gmif1;
    gif1_word[GIF_WAKE_BIT] = st_r.gflag[1].wake;
    gif1_word[GIF_RML_BIT] = rml1;
    gif1_word[GIF_BO_BIT] = st_r.gflag[1].bo;
    gif1_word[GIF_EP_BIT] = st_r.gflag[1].ep;
    gif1_word[GIF_WL_BIT] = st_r.gflag[1].wl;
    gif1_word[GIF_VEC_LSB +: VEC_W] = vif1.vec; // [R8]
  end

  // Write is taken only with address and data together and no response owed
  assign wr_go = s_axi_awvalid_i && s_axi_wvalid_i && !st_r.bvalid;
  assign rd_go = s_axi_arvalid_i && !st_r.rvalid;
  assign s_axi_awready_o = wr_go;
  assign s_axi_wready_o = wr_go;
  assign s_axi_arready_o = !st_r.rvalid;

  // Next-state logic for flags, registers and bus responses
  always_comb begin
    logic [31:0] bm;
    logic [31:0] clr;
    logic [31:0] wd;
    logic ln;
    bm = cgif_strb_mask(s_axi_wstrb_i);
    wd = s_axi_wdata_i & bm;
    clr = RST_WORD;
    ln = 1'b0;
    st_nxt = st_r;
    st_nxt.rmp_q = receive_pending_i;
    st_nxt.bo_q = bus_off_i;
    st_nxt.ep_q = error_passive_i;
    st_nxt.wl_q = warn_now;

    // Write-one-to-clear of global flags; lost flag and vector are not writable
    if (wr_go) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      case (s_axi_awaddr_i)
        OFS_GIF0, OFS_GIF1: begin
          clr = wd; // [R3] [R7]
          ln = (s_axi_awaddr_i == OFS_GIF1);
          st_nxt.gflag[ln].wake = st_r.gflag[ln].wake & ~clr[GIF_WAKE_BIT];
          st_nxt.gflag[ln].bo = st_r.gflag[ln].bo & ~clr[GIF_BO_BIT];
          st_nxt.gflag[ln].ep = st_r.gflag[ln].ep & ~clr[GIF_EP_BIT];
          st_nxt.gflag[ln].wl = st_r.gflag[ln].wl & ~clr[GIF_WL_BIT];
        end
        OFS_GIM: begin
          if (s_axi_wstrb_i[0]) begin
            st_nxt.global_line_select = wd[GIM_GIL_BIT];
            st_nxt.i1en = wd[GIM_I1EN_BIT];
            st_nxt.i0en = wd[GIM_I0EN_BIT];
          end
          if (s_axi_wstrb_i[1]) begin
            st_nxt.gmask = wd[GIF_WAKE_BIT:GIF_WL_BIT];
          end
        end
        OFS_MIM: begin
          st_nxt.mim = (st_r.mim & ~bm) | wd;
        end
        OFS_MIL: begin
          st_nxt.mil = (st_r.mil & ~bm) | wd;
        end
        OFS_CTRL: begin
          if (s_axi_wstrb_i[0]) begin
            st_nxt.compat = wd[CTRL_COMPAT_BIT];
          end
        end
        OFS_STAT, OFS_LOST: begin
          st_nxt.bresp = RESP_OKAY; // Read-only, write dropped
        end
        default: begin
          st_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end else if (st_r.bvalid && s_axi_bready_i) begin
      st_nxt.bvalid = 1'b0;
    end

    // Events are applied after the clears so a same-cycle set wins
    if (wake_event_i) begin
      st_nxt.gflag[st_r.global_line_select].wake = 1'b1; // [R1] [R14]
    end
    if (bus_off_i && !st_r.bo_q) begin
      st_nxt.gflag[st_r.global_line_select].bo = 1'b1; // [R4] [R14]
    end
    if (error_passive_i && !st_r.ep_q) begin
      st_nxt.gflag[st_r.global_line_select].ep = 1'b1; // [R5] [R14]
    end
    if (warn_now && !st_r.wl_q) begin
      st_nxt.gflag[st_r.global_line_select].wl = 1'b1; // [R6] [R14]
    end

    // Lost bit drops on a falling pending bit; a new overflow still wins
    st_nxt.lost = (st_r.lost & ~(st_r.rmp_q & ~receive_pending_i)) | rx_overflow_i; // [R2] [R3]

    // Read channel: data registered, held until rready
    if (rd_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      case (s_axi_araddr_i)
        OFS_GIF0: begin
          st_nxt.rdata = gif0_word;
        end
        OFS_GIF1: begin
          st_nxt.rdata = gif1_word;
        end
        OFS_GIM: begin
          st_nxt.rdata = RST_WORD;
          st_nxt.rdata[GIF_WAKE_BIT:GIF_WL_BIT] = st_r.gmask;
          st_nxt.rdata[GIM_GIL_BIT] = st_r.global_line_select;
          st_nxt.rdata[GIM_I1EN_BIT] = st_r.i1en;
          st_nxt.rdata[GIM_I0EN_BIT] = st_r.i0en;
        end
        OFS_MIM: begin
          st_nxt.rdata = st_r.mim;
        end
        OFS_MIL: begin
          st_nxt.rdata = st_r.mil;
        end
        OFS_CTRL: begin
          st_nxt.rdata = RST_WORD;
          st_nxt.rdata[CTRL_COMPAT_BIT] = st_r.compat;
        end
        OFS_STAT: begin
          st_nxt.rdata = RST_WORD;
          st_nxt.rdata[STAT_WL_BIT] = st_r.wl_q;
          st_nxt.rdata[STAT_EP_BIT] = st_r.ep_q;
          st_nxt.rdata[STAT_BO_BIT] = st_r.bo_q;
        end
        OFS_LOST: begin
          st_nxt.rdata = st_r.lost;
        end
        default: begin
          st_nxt.rdata = RST_WORD;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && s_axi_rready_i) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  // Single state register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Line outputs: global flags gated by their masks, mailbox flags by MIM
  always_comb begin
    logic g0;
    logic g1;
    g0 = |({st_r.gflag[0].wake, rml0, st_r.gflag[0].bo, st_r.gflag[0].ep,
            st_r.gflag[0].wl} & st_r.gmask);
    g1 = |({st_r.gflag[1].wake, rml1, st_r.gflag[1].bo, st_r.gflag[1].ep,
            st_r.gflag[1].wl} & st_r.gmask);
    irq_line_zero_o = st_r.i0en && (g0 || gmif0); // [R14] [R15]
    irq_line_one_o = st_r.i1en && (g1 || gmif1); // [R14] [R15]
    irq_o = irq_line_zero_o || irq_line_one_o;
  end

  assign s_axi_bvalid_o = st_r.bvalid;
  assign s_axi_bresp_o = st_r.bresp;
  assign s_axi_rvalid_o = st_r.rvalid;
  assign s_axi_rresp_o = st_r.rresp;
  assign s_axi_rdata_o = st_r.rdata;

endmodule

// *** hdl/cgif_pkg.sv ***
package cgif_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_GIF0 = 8'h00;
  localparam logic [7:0] OFS_GIF1 = 8'h04;
  localparam logic [7:0] OFS_GIM = 8'h08;
  localparam logic [7:0] OFS_MIM = 8'h0C;
  localparam logic [7:0] OFS_MIL = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_LOST = 8'h1C;

  // Flag register field positions
  localparam int GIF_GMIF_BIT = 15;
  localparam int GIF_WAKE_BIT = 12;
  localparam int GIF_RML_BIT = 11;
  localparam int GIF_BO_BIT = 10;
  localparam int GIF_EP_BIT = 9;
  localparam int GIF_WL_BIT = 8;
  localparam int GIF_VEC_LSB = 0;
  localparam int VEC_W = 5;

  // Global mask register field positions
  localparam int GIM_GIL_BIT = 2;
  localparam int GIM_I1EN_BIT = 1;
  localparam int GIM_I0EN_BIT = 0;

  // Control and status field positions
  localparam int CTRL_COMPAT_BIT = 0;
  localparam int STAT_WL_BIT = 0;
  localparam int STAT_EP_BIT = 1;
  localparam int STAT_BO_BIT = 2;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [VEC_W-1:0] RST_VEC = 5'h00;

  // Error counter warning threshold
  localparam logic [7:0] WARN_LEVEL = 8'h60;

  // Mailboxes visible in 16-mailbox compatibility mode
  localparam logic [31:0] COMPAT_MBX_MASK = 32'h0000_FFFF;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Highest set bit number of a mailbox set, zero when empty
  function automatic logic [VEC_W-1:0] cgif_highest(input logic [31:0] set);
    logic [VEC_W-1:0] idx;
    idx = RST_VEC;
    for (int i = 0; i < 32; i++) begin
      if (set[i]) begin
        idx = VEC_W'(i);
      end
    end
    return idx;
  endfunction

  // Expand AXI byte strobes into a bit mask
  function automatic logic [31:0] cgif_strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = RST_WORD;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

endpackage

// *** hdl/cgif_vec_if.sv ***
`timescale 1ns/100ps
interface cgif_vec_if;
  logic [31:0] pend;
  logic compat;
  logic [4:0] vec;

  modport src (
    output pend,
    output compat,
    input vec
  );
  modport sel (
    input pend,
    input compat,
    output vec
  );
endinterface

// *** hdl/cgif_vec.sv ***
`timescale 1ns/100ps
module cgif_vec
  import cgif_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  cgif_vec_if.sel vif
);

  typedef struct packed {
    logic [VEC_W-1:0] vec;
  } cgif_vec_st_t;

  cgif_vec_st_t st_r;
  cgif_vec_st_t st_nxt;
  logic [31:0] seen;

  // Compatibility mode hides mailboxes 16 to 31 from the vector
  always_comb begin
    seen = vif.compat ? (vif.pend & COMPAT_MBX_MASK) : vif.pend; // [R11]
    st_nxt = st_r;
    // A higher pending mailbox always takes over; the held number only moves
    // once it is cleared, since it is then no longer the highest  [R9]
    if (|seen) begin
      st_nxt.vec = cgif_highest(seen); // [R10]
    end
    if (vif.compat) begin
      st_nxt.vec[VEC_W-1] = 1'b0; // [R11]
    end
  end

  // With nothing pending the last number is kept, its top bit cleared in compatibility mode  [R12]
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign vif.vec = st_r.vec; // [R8]

endmodule

// *** dv/cgif_assertions.sv ***
`timescale 1ns/100ps
module cgif_assertions (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic irq_line_zero_o,
  input wire logic irq_line_one_o,
  input wire logic irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Handshake steps that the answers below hang from
  sequence s_wtake;
    s_axi_awvalid_i && s_axi_awready_o;
  endsequence
  sequence s_rtake;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  // A taken read of either flag word; both sit below byte address 8
  sequence s_flag_rd;
    s_axi_arvalid_i && s_axi_arready_o && (s_axi_araddr_i[7:3] == 5'h00);
  endsequence
  a_aw_pair: assert property (s_axi_awready_o |-> s_axi_wvalid_i && !s_axi_bvalid_o)
    else $error("write address taken without its data");
  a_write_resp: assert property (s_wtake |=> s_axi_bvalid_o)
    else $error("no write response after a taken write");
  a_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response dropped early");
  a_b_done: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response not retired");
  a_read_resp: assert property (s_rtake |=> s_axi_rvalid_o)
    else $error("no read data after a taken read");
  a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data changed while waiting");
  a_ar_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while data pending");
  a_irq_join: assert property (irq_o == (irq_line_zero_o || irq_line_one_o))
    else $error("summary interrupt disagrees with lines");
  a_flag_rsvd: assert property (s_flag_rd |=> s_axi_rdata_o[7:5] == 3'h0)
    else $error("reserved flag bits read nonzero");
endmodule
bind cgif_top cgif_assertions cgif_assertions_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
  .irq_line_zero_o(irq_line_zero_o), .irq_line_one_o(irq_line_one_o), .irq_o(irq_o));

// *** dv/cgif_core_model.sv ***
`timescale 1ns/100ps
module cgif_core_model (
  input wire logic sys_clk_i,
  output logic wake_o,
  output logic [31:0] ovf_o,
  output logic [31:0] rmp_o,
  output logic [31:0] ta_o,
  output logic bo_o,
  output logic ep_o,
  output logic [7:0] tec_o,
  output logic [7:0] rec_o
);
  // Quiet core at start so no edge is seen at reset release
  initial begin
    {wake_o, ovf_o, rmp_o, ta_o, bo_o, ep_o, tec_o, rec_o} = '0;
  end
  // Events last exactly one cycle, as the core produces them
  task automatic pulse(input logic w, input logic [31:0] o);
    @(posedge sys_clk_i);
    wake_o <= w;
    ovf_o <= o;
    @(posedge sys_clk_i);
    wake_o <= 1'b0;
    ovf_o <= '0;
  endtask
  // Core state levels; a rise here is an entry into that state
  task automatic lvl(input logic b, input logic e, input logic [7:0] t, input logic [7:0] r,
    input logic [31:0] p, input logic [31:0] a);
    @(posedge sys_clk_i);
    bo_o <= b;
    ep_o <= e;
    tec_o <= t;
    rec_o <= r;
    rmp_o <= p;
    ta_o <= a;
  endtask
endmodule

// *** dv/can_global_interrupt_flags_tb.sv ***
`timescale 1ns/100ps
module can_global_interrupt_flags_tb;
  import cgif_pkg::*;
  logic sys_clk_i, rst_i, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, wake, bo, ep, irq0, irq1, irq;
  logic [7:0] awaddr, araddr, tec, rec;
  logic [31:0] wdata, rdata, ovf, rmp, ta, rq;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, lresp;
  int n_fail, num_checks;
  cgif_top cgif_top_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .wake_event_i(wake), .rx_overflow_i(ovf),
    .receive_pending_i(rmp), .transmit_ack_i(ta), .bus_off_i(bo), .error_passive_i(ep),
    .tx_err_cnt_i(tec), .rx_err_cnt_i(rec), .irq_line_zero_o(irq0),
    .irq_line_one_o(irq1), .irq_o(irq));
  cgif_core_model cgif_core_model_i (.sys_clk_i(sys_clk_i), .wake_o(wake), .ovf_o(ovf),
    .rmp_o(rmp), .ta_o(ta), .bo_o(bo), .ep_o(ep), .tec_o(tec), .rec_o(rec));
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic summarize();
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Lines looked at mid-cycle, away from the edge that updates them; order irq, one, zero
  task automatic ck_irq(input logic [2:0] e);
    @(negedge sys_clk_i);
    chk({29'h0, irq, irq1, irq0}, {29'h0, e});
  endtask
  // Valid and payload held until the edge that samples ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge sys_clk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge sys_clk_i); while (awready !== 1'b1 || wready !== 1'b1);
    @(posedge sys_clk_i);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge sys_clk_i); while (bvalid !== 1'b1);
    lresp = bresp;
    @(posedge sys_clk_i);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge sys_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge sys_clk_i); while (arready !== 1'b1);
    @(posedge sys_clk_i);
    arvalid <= 1'b0;
    do @(negedge sys_clk_i); while (rvalid !== 1'b1);
    rq = rdata;
    lresp = rresp;
    @(posedge sys_clk_i);
    rready <= 1'b0;
    chk(rq & m, e);
  endtask
  // Watchdog sized well above the few hundred cycles the tests need
  initial begin
    #1000000;
    n_fail++;
    summarize();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    rst_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 32; a += 4) rd(8'(a), RST_WORD, 32'hFFFF_FFFF);
    chk({30'h0, lresp}, {30'h0, RESP_OKAY});
    ck_irq(3'h0);
    rd(8'h20, RST_WORD, 32'hFFFF_FFFF);
    chk({30'h0, lresp}, {30'h0, RESP_SLVERR});
    wr(8'h24, 32'h0, 4'hF);
    chk({30'h0, lresp}, {30'h0, RESP_SLVERR});
    // Wake on line zero; a low-byte write must not clear it
    wr(OFS_GIM, 32'h1F03, 4'hF);
    chk({30'h0, lresp}, {30'h0, RESP_OKAY});
    rd(OFS_GIM, 32'h1F03, 32'hFFFF_FFFF);
    cgif_core_model_i.pulse(1'b1, '0);
    wr(OFS_GIF0, 32'hFFFF_FFFF, 4'h1);
    rd(OFS_GIF0, 32'h1000, 32'h9F00);
    rd(OFS_GIF1, 32'h0, 32'h9F00);
    ck_irq(3'h5);
    // A set flag must stay off the line while its mask or line enable is low
    wr(OFS_GIM, 32'h0003, 4'hF);
    ck_irq(3'h0);
    wr(OFS_GIM, 32'h1F02, 4'hF);
    ck_irq(3'h0);
    wr(OFS_GIF0, 32'h1000, 4'h2);
    rd(OFS_GIF0, 32'h0, 32'h9F00);
    // Global flags on line one, warning threshold at its boundary
    wr(OFS_GIM, 32'h1F07, 4'hF);
    cgif_core_model_i.lvl(1'b1, 1'b0, 8'h00, 8'h00, '0, '0);
    rd(OFS_GIF1, 32'h0400, 32'h9F00);
    rd(OFS_GIF0, 32'h0, 32'h9F00);
    cgif_core_model_i.lvl(1'b1, 1'b1, 8'h5F, 8'h00, '0, '0);
    rd(OFS_GIF1, 32'h0600, 32'h9F00);
    cgif_core_model_i.lvl(1'b1, 1'b1, 8'h5F, 8'h60, '0, '0);
    rd(OFS_GIF1, 32'h0700, 32'h9F00);
    rd(OFS_STAT, 32'h7, 32'hFFFF_FFFF);
    ck_irq(3'h6);
    wr(OFS_GIF1, 32'h0700, 4'h2);
    rd(OFS_GIF1, 32'h0, 32'h9F00);
    // The transmit counter alone must reach the warning level too
    cgif_core_model_i.lvl(1'b1, 1'b1, 8'h00, 8'h00, '0, '0);
    cgif_core_model_i.lvl(1'b1, 1'b1, 8'h60, 8'h00, '0, '0);
    rd(OFS_GIF1, 32'h0100, 32'h9F00);
    wr(OFS_GIF1, 32'h0100, 4'h2);
    // Lost message follows its mailbox line and its pending bit
    wr(OFS_MIL, 32'h2, 4'hF);
    cgif_core_model_i.lvl(1'b0, 1'b0, 8'h00, 8'h00, 32'h2, '0);
    cgif_core_model_i.pulse(1'b0, 32'h2);
    rd(OFS_GIF1, 32'h0800, 32'h0800);
    rd(OFS_GIF0, 32'h0, 32'h0800);
    rd(OFS_LOST, 32'h2, 32'hFFFF_FFFF);
    wr(OFS_GIF1, 32'h0800, 4'hF);
    rd(OFS_GIF1, 32'h0800, 32'h0800);
    cgif_core_model_i.lvl(1'b0, 1'b0, 8'h00, 8'h00, '0, '0);
    rd(OFS_GIF1, 32'h0, 32'h0800);
    // Vector ranking in normal and 16-mailbox modes
    wr(OFS_MIM, 32'hFFFF_FFFF, 4'hF);
    rd(OFS_MIM, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    wr(OFS_MIL, 32'h0, 4'hF);
    cgif_core_model_i.lvl(1'b0, 1'b0, 8'h00, 8'h00, '0, 32'h8);
    rd(OFS_GIF0, 32'h8003, 32'h801F);
    cgif_core_model_i.lvl(1'b0, 1'b0, 8'h00, 8'h00, '0, 32'h8000_0008);
    rd(OFS_GIF0, 32'h801F, 32'h801F);
    cgif_core_model_i.lvl(1'b0, 1'b0, 8'h00, 8'h00, '0, 32'h8);
    rd(OFS_GIF0, 32'h8003, 32'h801F);
    wr(OFS_CTRL, 32'h1, 4'hF);
    rd(OFS_CTRL, 32'h1, 32'hFFFF_FFFF);
    cgif_core_model_i.lvl(1'b0, 1'b0, 8'h00, 8'h00, '0, 32'h0010_0020);
    rd(OFS_GIF0, 32'h8005, 32'h801F);
    cgif_core_model_i.lvl(1'b0, 1'b0, 8'h00, 8'h00, '0, 32'h0010_8020);
    rd(OFS_GIF0, 32'h800F, 32'h801F);
    cgif_core_model_i.lvl(1'b0, 1'b0, 8'h00, 8'h00, '0, 32'h0010_0000);
    rd(OFS_GIF0, 32'h0, 32'h8000);
    wr(OFS_CTRL, 32'h0, 4'hF);
    wr(OFS_MIL, 32'h20, 4'hF);
    cgif_core_model_i.lvl(1'b0, 1'b0, 8'h00, 8'h00, 32'h20, '0);
    rd(OFS_GIF1, 32'h8005, 32'h801F);
    rd(OFS_GIF0, 32'h0, 32'h8000);
    ck_irq(3'h6);
    wr(OFS_MIM, 32'h0, 4'hF);
    rd(OFS_GIF1, 32'h0, 32'h8000);
    ck_irq(3'h0);
    summarize();
  end
endmodule
